//--- rtl/vpiu_top.sv
`timescale 1ns/100ps
// What this block does
// - Fixed-priority vectors, 21 sources, 16 slots
// - Accept when disable 0, pending, enabled
// - Maskable sources own pending and enable
// - Reset uses vector FFFC/FFFD, top priority
// - Slot 2: edge zero or timer Z
// - Slot 3: edge one
// - Slot 4: serial 1 receive
// - Slot 5: serial 1 transmit
// - Slots 6,7: timers X and Y
// - Slots 8,9: timers 1 and 2
// - Slot 10 counter zero; 11 shared
// - Slot 12: serial 2 or timer Z
// - Slots 13,14: edge inputs two, three
// - Slot 15: edge four or counter two
// - Slot 16: converter or serial 3 transmit
// - Break trap, priority 17, FFDC/FFDD; taken here ahead of any pending maskable slot
// - Disable flag is status bit 2
// - Set and clear disable commands
// - Status stacked before flag is set
// - Return restores status from stack
// - Pending set by source, cleared on grant
// - Software clears pending, never sets
// - Enables read/write; pending still sets
// - Highest wins, others stay pending
// - Grant only at instruction end, except reset
// - Push high, low, status; load vector
// - Select bit chooses shared slot source
module vpiu_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [7:0]          edge_pins,
    input  wire vpiu_pkg::vpiu_evt_t evt,
    input  wire logic                instr_done,
    input  wire logic                break_op,
    input  wire logic                return_from_irq_op,
    input  wire logic [7:0]          stacked_status,
    output vpiu_pkg::vpiu_grant_t    grant,
    output logic [1:0]               push_step,
    output logic [7:0]               processor_status_reg,
    output logic [7:0]               status_push
);

    logic [14:0] req_r;
    logic [14:0] ena_r;
    logic [4:0]  srcsel_r;
    logic [7:0]  edge_r;
    logic [7:0]  ps_r;
    logic [7:0]  sync1_r;
    logic [7:0]  sync2_r;
    logic [7:0]  sync3_r;
    logic [14:0] src_fire;
    logic [14:0] live;
    logic [14:0] win;
    logic [7:0]  pin_edge;
    logic        wr_en;
    logic        rd_en;
    logic        accept;
    logic        cmd_set;
    logic        cmd_clr;
    logic        cmd_ret;
    logic        cmd_brk;
    logic        cmd_done;
    logic        done_any;
    logic        brk_any;
    logic        ret_any;
    logic        boot_r;
    vpiu_pkg::vpiu_state_t state_r;

    // fixed order over the maskable slots
    // Lowest set bit wins: bit 0 is priority 2
    function automatic logic [14:0] pick_first(input logic [14:0] v);
        logic [14:0] r;
        r = v & (~v + 15'h0001);
        return r;
    endfunction : pick_first

    // Index of a one-hot vector
    function automatic logic [3:0] onehot_idx(input logic [14:0] v);
        logic [3:0] k;
        k = 4'h0;
        for (int i = 0; i < vpiu_pkg::NSLOT; i++) begin
            if (v[i]) begin
                k = 4'(i);
            end
        end
        return k;
    endfunction : onehot_idx

    // APB decode; single-cycle answer
    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & ~penable & ~pwrite;
    assign cmd_set  = wr_en && paddr == vpiu_pkg::ADDR_CORE
                      && pwdata[vpiu_pkg::CMD_SET_DIS];
    assign cmd_clr  = wr_en && paddr == vpiu_pkg::ADDR_CORE
                      && pwdata[vpiu_pkg::CMD_CLR_DIS];
    assign cmd_ret  = wr_en && paddr == vpiu_pkg::ADDR_CORE
                      && pwdata[vpiu_pkg::CMD_RETURN];
    assign cmd_brk  = wr_en && paddr == vpiu_pkg::ADDR_CORE
                      && pwdata[vpiu_pkg::CMD_BREAK];
    assign cmd_done = wr_en && paddr == vpiu_pkg::ADDR_CORE
                      && pwdata[vpiu_pkg::CMD_DONE];
    assign done_any = instr_done | cmd_done;
    assign brk_any  = break_op | cmd_brk;
    assign ret_any  = return_from_irq_op | cmd_ret;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            sync3_r <= 8'h00;
        end else begin
            sync1_r <= edge_pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    generate
        for (genvar p = 0; p < vpiu_pkg::NPIN; p++) begin : g_edge
            assign pin_edge[p] = (sync2_r[p] != sync3_r[p])
                                 && (sync2_r[p] == ~edge_r[p]);
        end
    endgenerate

    assign src_fire[0]  = srcsel_r[0] ? evt.timer_z
                                      : pin_edge[vpiu_pkg::PIN_EXT_EDGE_IN_ZERO];
    assign src_fire[1]  = pin_edge[vpiu_pkg::PIN_EXT_EDGE_IN_ONE];
    assign src_fire[2]  = evt.sio1_rx;
    assign src_fire[3]  = evt.sio1_tx;
    assign src_fire[4]  = evt.timer_x;
    assign src_fire[5]  = evt.timer_y;
    assign src_fire[6]  = evt.timer_1;
    assign src_fire[7]  = evt.timer_2;
    assign src_fire[8]  = pin_edge[vpiu_pkg::PIN_CNT0];
    assign src_fire[9]  = srcsel_r[1] ? evt.sio3_rx
                                      : pin_edge[vpiu_pkg::PIN_CNT1];
    assign src_fire[10] = srcsel_r[2] ? evt.timer_z : evt.sio2_done;
    assign src_fire[11] = pin_edge[vpiu_pkg::PIN_EXT_EDGE_IN_TWO];
    assign src_fire[12] = pin_edge[vpiu_pkg::PIN_EXT_EDGE_IN_THREE];
    assign src_fire[13] = srcsel_r[3] ? pin_edge[vpiu_pkg::PIN_CNT2]
                                      : pin_edge[vpiu_pkg::PIN_EXT_EDGE_IN_FOUR];
    assign src_fire[14] = srcsel_r[4] ? evt.sio3_tx : evt.adc_done;

    assign live = (ps_r[vpiu_pkg::PS_DIS_BIT] || boot_r)
                  ? 15'h0000 : (req_r & ena_r);
    assign win = pick_first(live);
    assign accept = (state_r == vpiu_pkg::ST_RUN) && done_any
                    && !brk_any && (live != 15'h0000);

    // pending flags; set wins over clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= vpiu_pkg::REQ_RST;
        end else begin
            req_r <= (req_r
                      & ~(accept ? win : 15'h0000)
                      & ((wr_en && paddr == vpiu_pkg::ADDR_REQ)
                         ? pwdata[14:0] : 15'h7FFF))
                     | src_fire;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena_r    <= vpiu_pkg::ENA_RST;
            srcsel_r <= vpiu_pkg::SRCSEL_RST;
            edge_r   <= vpiu_pkg::EDGE_RST;
        end else if (wr_en) begin
            if (paddr == vpiu_pkg::ADDR_ENA) begin
                ena_r <= pwdata[14:0];
            end
            if (paddr == vpiu_pkg::ADDR_SRCSEL) begin
                srcsel_r <= pwdata[4:0];
            end
            if (paddr == vpiu_pkg::ADDR_EDGE) begin
                edge_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_r <= vpiu_pkg::PSTAT_RST;
        end else if (accept || (brk_any && done_any)) begin
            ps_r[vpiu_pkg::PS_DIS_BIT] <= 1'b1;
        end else if (ret_any) begin
            ps_r <= stacked_status;
        end else if (cmd_set) begin
            ps_r[vpiu_pkg::PS_DIS_BIT] <= 1'b1;
        end else if (cmd_clr) begin
            ps_r[vpiu_pkg::PS_DIS_BIT] <= 1'b0;
        end else if (wr_en && paddr == vpiu_pkg::ADDR_PSTAT) begin
            ps_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= vpiu_pkg::ST_RUN;
            boot_r      <= 1'b1;
            grant       <= '0;
            push_step   <= 2'b00;
            status_push <= 8'h00;
        end else begin
            grant.take <= 1'b0;
            unique case (state_r)
                vpiu_pkg::ST_RUN: begin
                    push_step <= 2'b00;
                    if (boot_r) begin
                        boot_r       <= 1'b0;
                        grant.take   <= 1'b1;
                        grant.vector <= vpiu_pkg::VEC_RESET;
                    end else if (done_any && brk_any) begin
                        grant.take   <= 1'b1;
                        grant.vector <= vpiu_pkg::VEC_BREAK;
                        status_push  <= ps_r;
                        push_step    <= 2'b01;
                        state_r      <= vpiu_pkg::ST_PUSH;
                    end else if (accept) begin
                        grant.take   <= 1'b1;
                        grant.vector <= vpiu_pkg::VEC_SLOT0
                            - {11'h000, onehot_idx(win), 1'b0};
                        status_push  <= ps_r;
                        push_step    <= 2'b01;
                        state_r      <= vpiu_pkg::ST_PUSH;
                    end
                end
                vpiu_pkg::ST_PUSH: begin
                    push_step <= 2'b10;
                    state_r   <= vpiu_pkg::ST_SERVE;
                end
                vpiu_pkg::ST_SERVE: begin
                    push_step <= 2'b11;
                    state_r   <= vpiu_pkg::ST_RUN;
                end
                default: begin
                    state_r <= vpiu_pkg::ST_RUN;
                end
            endcase
        end
    end

    assign processor_status_reg = ps_r;

    // APB read data, registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                vpiu_pkg::ADDR_REQ:    prdata <= {17'h00000, req_r};
                vpiu_pkg::ADDR_ENA:    prdata <= {17'h00000, ena_r};
                vpiu_pkg::ADDR_SRCSEL: prdata <= {27'h0000000, srcsel_r};
                vpiu_pkg::ADDR_EDGE:   prdata <= {24'h000000, edge_r};
                vpiu_pkg::ADDR_PSTAT:  prdata <= {24'h000000, ps_r};
                vpiu_pkg::ADDR_VECTOR: prdata <= {14'h0000, state_r,
                                                  grant.vector};
                default:               prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Ready in access phase; unmapped gets error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > vpiu_pkg::ADDR_VECTOR
                       || paddr[1:0] != 2'b00);
        end
    end

    chk_req_no_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == vpiu_pkg::ADDR_REQ && src_fire == 15'h0000
        |=> (req_r & ~$past(req_r)) == 15'h0000)
        else $error("software write set a pending flag");

    chk_grant_clears: assert property (@(posedge pclk)
        disable iff (!presetn)
        accept && !src_fire[onehot_idx(win)]
        |=> !req_r[$past(onehot_idx(win))])
        else $error("granted pending flag not cleared");

    chk_dis_blocks: assert property (@(posedge pclk)
        disable iff (!presetn)
        ps_r[vpiu_pkg::PS_DIS_BIT] |-> !accept)
        else $error("accepted while disabled");

    chk_dis_after: assert property (@(posedge pclk)
        disable iff (!presetn)
        accept |=> ps_r[vpiu_pkg::PS_DIS_BIT]
                   && !status_push[vpiu_pkg::PS_DIS_BIT])
        else $error("status not stacked before disable set");

    sequence push_walk;
        push_step == 2'b01 ##1 push_step == 2'b10 ##1 push_step == 2'b11;
    endsequence
    chk_push_order: assert property (@(posedge pclk)
        disable iff (!presetn)
        grant.take && grant.vector != vpiu_pkg::VEC_RESET |-> push_walk)
        else $error("push sequence out of order");

    chk_others_kept: assert property (@(posedge pclk)
        disable iff (!presetn)
        accept && !(wr_en && paddr == vpiu_pkg::ADDR_REQ)
        |=> (($past(req_r) & ~$past(win)) & ~req_r) == 15'h0000)
        else $error("losing request disturbed");

    chk_break_vec: assert property (@(posedge pclk)
        disable iff (!presetn)
        state_r == vpiu_pkg::ST_RUN && !boot_r && done_any && brk_any
        |=> grant.take && grant.vector == vpiu_pkg::VEC_BREAK)
        else $error("break trap not vectored");

    chk_at_end: assert property (@(posedge pclk)
        disable iff (!presetn)
        accept |-> done_any)
        else $error("accepted mid-instruction");

    chk_clear_cmd: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmd_clr && !cmd_set && !ret_any && !accept && !brk_any
        |=> !ps_r[vpiu_pkg::PS_DIS_BIT])
        else $error("clear-disable ignored");

endmodule : vpiu_top

//--- rtl/vpiu_pkg.sv
package vpiu_pkg;

    // Number of maskable vector slots (priorities 2..16)
    localparam int NSLOT = 15;
    localparam int NPIN  = 8;

    // APB register byte addresses
    localparam logic [7:0] ADDR_REQ    = 8'h00;
    localparam logic [7:0] ADDR_ENA    = 8'h04;
    localparam logic [7:0] ADDR_SRCSEL = 8'h08;
    localparam logic [7:0] ADDR_EDGE   = 8'h0C;
    localparam logic [7:0] ADDR_PSTAT  = 8'h10;
    localparam logic [7:0] ADDR_CORE   = 8'h14;
    localparam logic [7:0] ADDR_VECTOR = 8'h18;

    // Reset values
    localparam logic [14:0] REQ_RST    = 15'h0000;
    localparam logic [14:0] ENA_RST    = 15'h0000;
    localparam logic [4:0]  SRCSEL_RST = 5'h00;
    localparam logic [7:0]  EDGE_RST   = 8'h00;
    localparam logic [7:0]  PSTAT_RST  = 8'h04;

    // Disable flag position in the status byte
    localparam int PS_DIS_BIT = 2;

    // Core command bits written at ADDR_CORE
    localparam int CMD_SET_DIS = 0;
    localparam int CMD_CLR_DIS = 1;
    localparam int CMD_RETURN  = 2;
    localparam int CMD_BREAK   = 3;
    localparam int CMD_DONE    = 4;

    // Pin index inside the edge pin vector
    localparam int PIN_EXT_EDGE_IN_ZERO = 0;
    localparam int PIN_EXT_EDGE_IN_ONE = 1;
    localparam int PIN_EXT_EDGE_IN_TWO = 2;
    localparam int PIN_EXT_EDGE_IN_THREE = 3;
    localparam int PIN_EXT_EDGE_IN_FOUR = 4;
    localparam int PIN_CNT0 = 5;
    localparam int PIN_CNT1 = 6;
    localparam int PIN_CNT2 = 7;

    // Low vector bytes
    localparam logic [15:0] VEC_RESET = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK = 16'hFFDC;
    localparam logic [15:0] VEC_SLOT0 = 16'hFFFA;

    // Internal event inputs grouped as a struct
    typedef struct packed {
        logic timer_z;
        logic sio1_rx;
        logic sio1_tx;
        logic timer_x;
        logic timer_y;
        logic timer_1;
        logic timer_2;
        logic sio3_rx;
        logic sio2_done;
        logic adc_done;
        logic sio3_tx;
    } vpiu_evt_t;

    // Grant to the core
    typedef struct packed {
        logic        take;
        logic [15:0] vector;
    } vpiu_grant_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_PUSH  = 2'b01,
        ST_SERVE = 2'b11
    } vpiu_state_t;

endpackage : vpiu_pkg

//--- test/vpiu_core_model.sv
`timescale 1ns/100ps
module vpiu_core_model (
    input  wire logic                  pclk,
    input  wire vpiu_pkg::vpiu_grant_t grant,
    input  wire logic [7:0]            status_push,
    output logic                       instr_done,
    output logic                       break_op,
    output logic                       return_from_irq_op,
    output logic [7:0]                 stacked_status
);
    logic [7:0] stk [8];
    int         sp = 0;

    initial begin
        instr_done         = 1'b0;
        break_op           = 1'b0;
        return_from_irq_op = 1'b0;
        stacked_status     = 8'h00;
    end

    always @(posedge pclk) begin
        if (grant.take === 1'b1 && grant.vector !== vpiu_pkg::VEC_RESET) begin
            stk[sp] = status_push;
            sp      = sp + 1;
        end
    end

    task end_instr(input logic software_break_trap);
        instr_done <= 1'b1;
        break_op   <= software_break_trap;
        @(posedge pclk);
        instr_done <= 1'b0;
        break_op   <= 1'b0;
    endtask : end_instr

    task ret_irq;
        sp                  = sp - 1;
        stacked_status     <= stk[sp];
        return_from_irq_op <= 1'b1;
        @(posedge pclk);
        return_from_irq_op <= 1'b0;
        stacked_status     <= ~stk[sp];
    endtask : ret_irq
endmodule : vpiu_core_model

//--- test/vectored_priority_interrupt_unit_bench.sv
`timescale 1ns/100ps
module vectored_priority_interrupt_unit_bench;
    logic                  pclk;
    logic                  presetn;
    logic [7:0]            paddr;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [7:0]            edge_pins;
    vpiu_pkg::vpiu_evt_t   evt;
    vpiu_pkg::vpiu_evt_t   ev;
    logic                  instr_done;
    logic                  break_op;
    logic                  ret_op;
    logic [7:0]            stacked_status;
    vpiu_pkg::vpiu_grant_t grant;
    logic [1:0]            push_step;
    logic [7:0]            ps;
    logic [7:0]            status_push;
    logic [15:0]           last_vec;
    logic [7:0]            st_take;
    logic [7:0]            ps_take;
    logic [1:0]            step_take;
    logic [31:0]           rd;
    logic                  err;
    int                    n_fail = 0;
    int                    total_checks = 0;
    int                    n_take = 0;

    vpiu_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edge_pins(edge_pins), .evt(evt), .instr_done(instr_done),
        .break_op(break_op), .return_from_irq_op(ret_op),
        .stacked_status(stacked_status), .grant(grant),
        .push_step(push_step), .processor_status_reg(ps),
        .status_push(status_push));

    vpiu_core_model core_u (.pclk(pclk), .grant(grant),
        .status_push(status_push), .instr_done(instr_done),
        .break_op(break_op), .return_from_irq_op(ret_op),
        .stacked_status(stacked_status));

    // Clock of 100 ns period
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // Records each grant and the status seen with it
    always @(posedge pclk) begin
        if (grant.take === 1'b1) begin
            n_take    <= n_take + 1;
            last_vec  <= grant.vector;
            st_take   <= ps;
            ps_take   <= status_push;
            step_take <= push_step;
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            $display("ERROR t=%0t no pready", $time);
            give_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rd_chk

    task pulse(input vpiu_pkg::vpiu_evt_t e);
        evt <= e;
        @(posedge pclk);
        evt <= '0;
        @(posedge pclk);
    endtask : pulse

    // Waits for a grant, then lets the push walk finish
    task see_take(input logic [15:0] v);
        int i;
        int k0;
        k0 = n_take;
        for (i = 0; i < 8 && n_take == k0; i++) @(posedge pclk);
        if (n_take == k0) begin
            n_fail++;
            $display("ERROR t=%0t no grant", $time);
            give_verdict();
        end else begin
            chk({16'h0000, last_vec}, {16'h0000, v});
            repeat (4) @(posedge pclk);
        end
    endtask : see_take

    task no_take;
        int k0;
        k0 = n_take;
        repeat (6) @(posedge pclk);
        chk(n_take, k0);
    endtask : no_take

    initial begin
        presetn = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        edge_pins = 8'h00;
        evt = '0;
        ev = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({16'h0000, last_vec}, 32'h0000_FFFC);
        rd_chk(vpiu_pkg::ADDR_PSTAT, 32'h0000_0004);
        rd_chk(vpiu_pkg::ADDR_ENA, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, vpiu_pkg::ADDR_CORE, 32'h0000_0002);
        rd_chk(vpiu_pkg::ADDR_PSTAT, 32'h0000_0000);
        ev.timer_x = 1'b1;
        ev.timer_y = 1'b1;
        pulse(ev);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0030);
        core_u.end_instr(1'b0);
        no_take();
        apb(1'b1, vpiu_pkg::ADDR_REQ, 32'h0000_0020);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0020);
        apb(1'b1, vpiu_pkg::ADDR_REQ, 32'h0000_7FFF);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0020);
        ev.timer_y = 1'b0;
        pulse(ev);
        apb(1'b1, vpiu_pkg::ADDR_ENA, 32'h0000_7FFF);
        rd_chk(vpiu_pkg::ADDR_ENA, 32'h0000_7FFF);
        core_u.end_instr(1'b0);
        see_take(16'hFFF2);
        chk({24'h0, st_take}, 32'h0000_0004);
        chk({24'h0, ps_take}, 32'h0000_0000);
        chk({30'h0, step_take}, 32'h0000_0001);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0020);
        core_u.end_instr(1'b0);
        no_take();
        core_u.ret_irq();
        rd_chk(vpiu_pkg::ADDR_PSTAT, 32'h0000_0000);
        core_u.end_instr(1'b0);
        see_take(16'hFFF0);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        apb(1'b1, vpiu_pkg::ADDR_CORE, 32'h0000_0002);
        apb(1'b1, vpiu_pkg::ADDR_CORE, 32'h0000_0001);
        rd_chk(vpiu_pkg::ADDR_PSTAT, 32'h0000_0004);
        core_u.end_instr(1'b1);
        see_take(16'hFFDC);
        edge_pins <= 8'h02;
        repeat (8) @(posedge pclk);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0002);
        apb(1'b1, vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        edge_pins <= 8'h00;
        repeat (8) @(posedge pclk);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        apb(1'b1, vpiu_pkg::ADDR_SRCSEL, 32'h0000_0001);
        apb(1'b1, vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        ev = '0;
        ev.timer_z = 1'b1;
        pulse(ev);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0001);
        // Falling polarity on edge one: rise ignored, fall counted
        apb(1'b1, vpiu_pkg::ADDR_EDGE, 32'h0000_0002);
        apb(1'b1, vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        edge_pins <= 8'h02;
        repeat (8) @(posedge pclk);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0000);
        edge_pins <= 8'h00;
        repeat (8) @(posedge pclk);
        rd_chk(vpiu_pkg::ADDR_REQ, 32'h0000_0002);
        give_verdict();
    end
endmodule : vectored_priority_interrupt_unit_bench
